/* core/gpc_pin_one.sv */
// Top of the pin-one function block: registers, reset decision and pin
module gpc_pin_one (
    // ==========================================================
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,

    // ==========================================================
    // Register access port from the management bus engine
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,

    // ==========================================================
    // Comparator results from the monitor
    input  wire logic [7:0] prim_exceed,
    input  wire logic [7:0] reset_thresh_fault,
    input  wire logic [6:0] fault_cond,
    output logic [2:0]      reset_threshold_select,

    // ==========================================================
    // General pin one, split into its three signals
    input  wire logic       general_pin_one_in,
    output logic            general_pin_one_out,
    output logic            general_pin_one_oe,

    // ==========================================================
    // Reset output, active low
    output logic            reset_out_n
);

    // ==========================================================
    // Register storage
    logic [7:0] rst_mask;         // Reset dependency mask, one bit per input
    logic [2:0] next_thresh_sel;  // Next reset threshold choice
    logic [2:0] pin_mode_q;       // Mode field
    logic [2:0] thresh_in_sel;    // threshold_input_select
    logic       out_level;        // Output-level bit
    logic [6:0] fault_sel;        // pin_fault_condition_select

    // ==========================================================
    // Pin level after synchronising
    logic pin_level;              // Filtered level of the pad

    gpc_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (general_pin_one_in),
        .level    (pin_level)
    );

    // ==========================================================
    // Address decode, kept as named wires
    wire hit_thresh = (reg_addr == gpc_pkg::ADDR_RST_THRESH);
    wire hit_mask   = (reg_addr == gpc_pkg::ADDR_RST_MASK);
    wire hit_ctrl   = (reg_addr == gpc_pkg::ADDR_PIN_CTRL);
    wire hit_fault  = (reg_addr == gpc_pkg::ADDR_FAULT_SEL);

    wire wr_thresh  = reg_wr && hit_thresh;
    wire wr_mask    = reg_wr && hit_mask;
    wire wr_ctrl    = reg_wr && hit_ctrl;
    wire wr_fault   = reg_wr && hit_fault;

    // ==========================================================
    // Threshold selection register; the value leaves as a port
    // so the comparators can pick their limits from it
    assign next_thresh_sel = wr_thresh ? reg_wdata[2:0] : reset_threshold_select;

    always_ff @(posedge clk) begin
        if (rst) begin
            reset_threshold_select <= gpc_pkg::RST_THRESH;
        end else begin
            reset_threshold_select <= next_thresh_sel;
        end
    end

    // ==========================================================
    // Reset dependency mask
    always_ff @(posedge clk) begin
        if (rst) begin
            rst_mask <= gpc_pkg::RST_MASK;
        end else if (wr_mask) begin
            rst_mask <= reg_wdata;
        end
    end

    // ==========================================================
    // Pin control register; the input-state bit is not stored,
    // so a write there is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_mode_q    <= gpc_pkg::RST_PIN_CTRL[gpc_pkg::MODE_LSB +: 3];
            thresh_in_sel <= gpc_pkg::RST_PIN_CTRL[gpc_pkg::SEL_LSB +: 3];
            out_level     <= gpc_pkg::RST_PIN_CTRL[gpc_pkg::OUT_LEVEL_BIT];
        end else if (wr_ctrl) begin
            pin_mode_q    <= reg_wdata[gpc_pkg::MODE_LSB +: 3];
            thresh_in_sel <= reg_wdata[gpc_pkg::SEL_LSB +: 3];
            out_level     <= reg_wdata[gpc_pkg::OUT_LEVEL_BIT];
        end
    end

    // ==========================================================
    // Fault condition select for the fault-output modes
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_sel <= gpc_pkg::RST_FAULT_SEL;
        end else if (wr_fault) begin
            fault_sel <= reg_wdata[6:0];
        end
    end

    // ==========================================================
    // Mode as the enumerated type
    gpc_pkg::gpc_mode_t pin_mode;
    assign pin_mode = gpc_pkg::gpc_mode_t'(pin_mode_q);

    // ==========================================================
    // Drive decision for the pad
    logic drive_en;      // Pad enable wanted this cycle
    logic drive_level;   // Pad level wanted this cycle

    gpc_drive u_drive (
        .mode        (pin_mode),
        .input_sel   (thresh_in_sel),
        .out_level   (out_level),
        .prim_exceed (prim_exceed),
        .fault_cond  (fault_cond),
        .fault_sel   (fault_sel),
        .drive_en    (drive_en),
        .drive_level (drive_level)
    );

    // ==========================================================
    // Pad outputs are registered; one cycle of lag is the price
    // of glitch-free pins when the mode field changes
    always_ff @(posedge clk) begin
        if (rst) begin
            general_pin_one_oe  <= 1'b0;   // Undriven until configured
            general_pin_one_out <= 1'b1;
        end else begin
            general_pin_one_oe  <= drive_en;
            general_pin_one_out <= drive_level;
        end
    end

    // ==========================================================
    // Reset decision
    // Input eight joins through mask bit 7 like the others; the
    // comparators already applied the chosen thresholds
    wire [6:0] rst_dep = rst_mask[6:0] & reset_thresh_fault[6:0];  // Inputs one to seven
    wire       in8_dep = rst_mask[gpc_pkg::MASK_IN8_BIT] &&
                         reset_thresh_fault[7];

    // Manual reset asserts on a low pad, and only in its own mode
    wire manual_rst = (pin_mode == gpc_pkg::GPC_MODE_MRESET) && !pin_level;

    wire next_reset_n = !(|rst_dep || in8_dep || manual_rst);

    always_ff @(posedge clk) begin
        if (rst) begin
            reset_out_n <= 1'b0;   // Hold the system in reset with us
        end else begin
            reset_out_n <= next_reset_n;
        end
    end

    // ==========================================================
    // Read data mux; unmapped addresses read as zero
    wire [7:0] ctrl_view = {pin_level,
                            out_level,
                            thresh_in_sel,
                            pin_mode_q};

    wire [7:0] rd_mux = hit_thresh ? {5'h0_0, reset_threshold_select} :
                        hit_mask   ? rst_mask :
                        hit_ctrl   ? ctrl_view :
                        hit_fault  ? {1'b0, fault_sel} :
                                     8'h00;

    // ==========================================================
    // Read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? rd_mux : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

endmodule : gpc_pin_one

/* core/gpc_pkg.sv */
// Package: register map, field layout and modes of the pin-one control block
package gpc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_RST_THRESH = 8'h20;   // Reset threshold selection
    localparam logic [7:0] ADDR_RST_MASK   = 8'h21;   // Reset dependency mask
    localparam logic [7:0] ADDR_PIN_CTRL   = 8'h22;   // pin_one_function_control
    localparam logic [7:0] ADDR_FAULT_SEL  = 8'h23;   // pin_fault_condition_select

    // ==========================================================
    // Field positions
    localparam int MODE_LSB       = 0;                // Mode field [2:0]
    localparam int SEL_LSB        = 3;                // threshold_input_select [5:3]
    localparam int OUT_LEVEL_BIT  = 6;                // Output-level bit
    localparam int IN_STATE_BIT   = 7;                // Input-state bit, read only
    localparam int MASK_IN8_BIT   = 7;                // Mask bit for input eight

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_PIN_CTRL   = 8'h00;    // Pin starts as plain input
    localparam logic [7:0] RST_MASK       = 8'h00;    // No input gates reset
    localparam logic [2:0] RST_THRESH     = 3'h0;     // Default threshold choice
    localparam logic [6:0] RST_FAULT_SEL  = 7'h00;    // No fault condition chosen

    // ==========================================================
    // Pin modes
    typedef enum logic [2:0] {
        GPC_MODE_INPUT  = 3'b000,
        GPC_MODE_MRESET = 3'b001,
        GPC_MODE_SWOUT  = 3'b010,
        GPC_MODE_FAULT  = 3'b011,
        GPC_MODE_THRESH = 3'b100,
        GPC_MODE_BOTH   = 3'b101,
        GPC_MODE_RSVD   = 3'b110,
        GPC_MODE_UNDEF  = 3'b111
    } gpc_mode_t;

endpackage : gpc_pkg

/* core/gpc_sync.sv */
// Three-stage synchroniser with agreement filter for the pin input
module gpc_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level
);

    // ==========================================================
    // Synchroniser chain
    logic s1;   // Metastable stage, read only by s2
    logic s2;   // Second stage
    logic s3;   // Third stage

    // Chain is not reset so a pin held at either level settles cleanly
    always_ff @(posedge clk) begin
        s1 <= async_in;
        s2 <= s1;
        s3 <= s2;
    end

    // ==========================================================
    // Accept a new level only when stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 1'b1;      // Idle-high guess keeps manual reset quiet
        end else if (s2 == s3) begin
            level <= s3;
        end
    end

endmodule : gpc_sync

/* core/gpc_drive.sv */
// Pin drive decision from mode, thresholds and fault conditions
module gpc_drive (
    input  wire gpc_pkg::gpc_mode_t mode,
    input  wire logic [2:0]         input_sel,
    input  wire logic               out_level,
    input  wire logic [7:0]         prim_exceed,
    input  wire logic [6:0]         fault_cond,
    input  wire logic [6:0]         fault_sel,
    output logic                    drive_en,
    output logic                    drive_level
);

    // ==========================================================
    // One-hot match of the selected input against its exceed flag
    logic [7:0] sel_hit;   // Per-input selected and exceeded
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_sel
            assign sel_hit[i] = (input_sel == 3'(i)) && prim_exceed[i];
        end
    endgenerate

    wire thresh_hit = |sel_hit;                  // Selected input out of limits
    wire fault_hit  = |(fault_cond & fault_sel); // Any chosen fault active

    // ==========================================================
    // Mode decode; fault and threshold outputs assert low, as the monitor outputs do
    always_comb begin
        drive_en    = 1'b0;
        drive_level = 1'b1;
        case (mode)
            gpc_pkg::GPC_MODE_INPUT: begin
                drive_en = 1'b0;
            end
            gpc_pkg::GPC_MODE_MRESET: begin
                drive_en = 1'b0;
            end
            gpc_pkg::GPC_MODE_SWOUT: begin
                drive_en    = 1'b1;
                drive_level = out_level;
            end
            gpc_pkg::GPC_MODE_FAULT: begin
                drive_en    = 1'b1;
                drive_level = !fault_hit;
            end
            gpc_pkg::GPC_MODE_THRESH: begin
                drive_en    = 1'b1;
                drive_level = !thresh_hit;
            end
            gpc_pkg::GPC_MODE_BOTH: begin
                drive_en    = 1'b1;
                drive_level = !(thresh_hit || fault_hit);
            end
            default: begin
                drive_en    = 1'b0;
                drive_level = 1'b1;
            end
        endcase
    end

endmodule : gpc_drive

/* dv/gpc_pin_one_props.sv */
// Checker for the pin-one block, tracking its control registers from the writes
module gpc_pin_one_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic [7:0] prim_exceed,
    input wire logic [7:0] reset_thresh_fault,
    input wire logic [6:0] fault_cond,
    input wire logic       general_pin_one_out,
    input wire logic       general_pin_one_oe,
    input wire logic       reset_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Shadow registers; they load on the same edge as the block's own
    logic [6:0] ctrl;  // Mode, select, level
    logic [7:0] mask;  // Reset dependency mask
    logic [6:0] fsel;  // Fault condition select
    wire  [2:0] mode = ctrl[2:0];
    wire        thr  = prim_exceed[ctrl[5:3]];
    wire        hit  = |(fault_cond & fsel);
    // Capture writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= 7'h00;
            mask <= 8'h00;
            fsel <= 7'h00;
        end else if (reg_wr) begin
            if (reg_addr == gpc_pkg::ADDR_PIN_CTRL) ctrl <= reg_wdata[6:0];
            if (reg_addr == gpc_pkg::ADDR_RST_MASK) mask <= reg_wdata;
            if (reg_addr == gpc_pkg::ADDR_FAULT_SEL) fsel <= reg_wdata[6:0];
        end
    end
    // ==========================================================
    // Properties; outputs follow their causes one edge later
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_pin_released: assert property (mode inside {0, 1, 6, 7} |=> !general_pin_one_oe)
        else $error("pin driven in an input mode");
    chk_swout_drive: assert property (mode == 3'h2 |=> general_pin_one_oe
        && general_pin_one_out == $past(ctrl[6])) else $error("software level not driven");
    chk_fault_out: assert property (mode == 3'h3 |=> general_pin_one_oe
        && general_pin_one_out == !$past(hit)) else $error("fault output wrong");
    chk_thresh_low: assert property (mode == 3'h4 |=> general_pin_one_oe
        && general_pin_one_out == !$past(thr)) else $error("threshold output wrong");
    chk_both_out: assert property (mode == 3'h5 |=> general_pin_one_oe
        && general_pin_one_out == !($past(thr) || $past(hit))) else $error("combined output wrong");
    chk_mask_eight: assert property (mask[7] && reset_thresh_fault[7] |=> !reset_out_n)
        else $error("input eight did not assert reset");
    // The releasing edge still samples rst high and the block holds reset_out_n low there
    chk_reset_idle: assert property (!rst && mask == 8'h00 && mode != 3'h1 |=> reset_out_n)
        else $error("reset asserted with no cause");
    chk_rvalid_pulse: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
        else $error("read valid pulse wrong");
    chk_rd_ctrl: assert property (reg_rd && reg_addr == gpc_pkg::ADDR_PIN_CTRL
        |=> reg_rdata[6:0] == $past(ctrl)) else $error("control readback wrong");
endmodule : gpc_pin_one_props

bind gpc_pin_one gpc_pin_one_props u_gpc_pin_one_props (.clk, .rst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .prim_exceed, .reset_thresh_fault,
    .fault_cond, .general_pin_one_out, .general_pin_one_oe, .reset_out_n);

/* dv/gpc_board_model.sv */
// Board-side model of the general pin with its pull-up
module gpc_board_model (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic board_level,
    output logic      pad
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Board level shows only while the block lets go of the pin
    assign pad = pin_oe ? pin_out : board_level;
endmodule : gpc_board_model

/* dv/tb_gpc_pin_one.sv */
// Self-checking bench for the pin-one function block
module tb_gpc_pin_one;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Ordinary-case row: stimulus, then expected enable and level
    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] sel;
        logic       lvl;
        logic [6:0] fsel;
        logic [7:0] prim;
        logic [6:0] flt;
        logic       oe;
        logic       out;
    } gpc_row_t;
    logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, prim_exceed = 8'h00;
    logic [7:0] reset_thresh_fault = 8'h00, reg_rdata, rdv;
    logic [6:0] fault_cond = 7'h00;
    logic [2:0] reset_threshold_select;
    logic       reg_rvalid, pad, pin_out, pin_oe, reset_out_n;
    logic       board_level = 1'b1;  // Pull-up level when released
    int         miscompares = 0, comparisons = 0, n;
    gpc_row_t   rows [13] = '{
        '{3'h0, 3'h0, 1'b0, 7'h00, 8'h00, 7'h00, 1'b0, 1'b0},
        '{3'h1, 3'h0, 1'b0, 7'h00, 8'h00, 7'h00, 1'b0, 1'b0},
        '{3'h2, 3'h0, 1'b1, 7'h00, 8'h00, 7'h00, 1'b1, 1'b1},
        '{3'h2, 3'h0, 1'b0, 7'h00, 8'h00, 7'h00, 1'b1, 1'b0},
        '{3'h3, 3'h0, 1'b0, 7'h01, 8'h00, 7'h01, 1'b1, 1'b0},
        '{3'h3, 3'h0, 1'b0, 7'h01, 8'h00, 7'h02, 1'b1, 1'b1},
        '{3'h4, 3'h0, 1'b0, 7'h00, 8'h01, 7'h00, 1'b1, 1'b0},
        '{3'h4, 3'h7, 1'b0, 7'h00, 8'h80, 7'h00, 1'b1, 1'b0},
        '{3'h4, 3'h7, 1'b0, 7'h7f, 8'h7f, 7'h7f, 1'b1, 1'b1},
        '{3'h5, 3'h3, 1'b0, 7'h40, 8'h00, 7'h40, 1'b1, 1'b0},
        '{3'h5, 3'h3, 1'b0, 7'h40, 8'hf7, 7'h3f, 1'b1, 1'b1},
        '{3'h6, 3'h0, 1'b1, 7'h00, 8'h00, 7'h00, 1'b0, 1'b0},
        '{3'h7, 3'h0, 1'b1, 7'h00, 8'h00, 7'h00, 1'b0, 1'b0}};

    gpc_pin_one u_gpc_pin_one (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid, .prim_exceed, .reset_thresh_fault, .fault_cond,
        .reset_threshold_select, .general_pin_one_in(pad), .general_pin_one_out(pin_out),
        .general_pin_one_oe(pin_oe), .reset_out_n);
    gpc_board_model u_gpc_board_model (.pin_out, .pin_oe, .board_level, .pad);

    // ==========================================================
    // Clock and bus tasks
    always #50 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read waits a bounded time for the valid pulse
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 4) begin
            miscompares++;
            results();
        end
        rdv = reg_rdata;
    endtask : rd
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(8'h22);
        chk("reset ctrl", rdv, 8'h80);
        chk("reset oe", {7'h00, pin_oe}, 8'h00);
        rd(8'h30);
        chk("unmapped", rdv, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(8'h23, {1'b0, rows[i].fsel});
            wr(8'h22, {1'b0, rows[i].lvl, rows[i].sel, rows[i].mode});
            prim_exceed <= rows[i].prim;
            fault_cond  <= rows[i].flt;
            repeat (6) @(posedge clk);
            #1;
            chk("oe", {7'h00, pin_oe}, {7'h00, rows[i].oe});
            if (rows[i].oe) chk("out", {7'h00, pin_out}, {7'h00, rows[i].out});
            rd(8'h22);
            chk("state", {rdv[7], 7'h00}, {rows[i].oe ? rows[i].out : 1'b1, 7'h00});
            $display("row %0d done", i);
        end
        wr(8'h20, 8'hff);
        rd(8'h20);
        chk("thresh sel", rdv, 8'h07);
        chk("thresh port", {5'h00, reset_threshold_select}, 8'h07);
        $display("threshold select test done");
        wr(8'h21, 8'h80);
        reset_thresh_fault <= 8'h7f;
        repeat (3) @(posedge clk);
        chk("mask off", {7'h00, reset_out_n}, 8'h01);
        reset_thresh_fault <= 8'h80;
        repeat (3) @(posedge clk);
        chk("mask eight", {7'h00, reset_out_n}, 8'h00);
        reset_thresh_fault <= 8'h00;
        $display("reset mask test done");
        wr(8'h22, 8'h01);
        board_level <= 1'b0;
        for (n = 0; n < 10 && reset_out_n !== 1'b0; n++) @(posedge clk);
        chk("manual reset", {7'h00, reset_out_n}, 8'h00);
        rd(8'h22);
        chk("manual state", rdv, 8'h01);
        board_level <= 1'b1;
        repeat (8) @(posedge clk);
        chk("manual end", {7'h00, reset_out_n}, 8'h01);
        $display("manual reset test done");
        // Mid-run reset: the control and mask registers must return to their reset values
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(8'h22);
        chk("reset again ctrl", rdv, 8'h80);
        chk("reset again oe", {7'h00, pin_oe}, 8'h00);
        rd(8'h21);
        chk("reset again mask", rdv, 8'h00);
        chk("reset again out", {7'h00, reset_out_n}, 8'h01);
        $display("mid-run reset test done");
        results();
    end
endmodule : tb_gpc_pin_one
